// >>> verilog/apmc_power_mode_control.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module apmc_power_mode_control import apmc_pkg::*; #(
    parameter int SAMPLE_CYC_FAST = APMC_SAMPLE_CYC_FAST,
    parameter int SAMPLE_W = 16,
    parameter int BUF_AW = 5
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [SAMPLE_W-1:0] sample_data,
    output logic measure_mode,
    output logic sense_en,
    output logic lp_active,
    output logic conv_strobe,
    output logic sample_strobe
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        apmc_mode_e mode;
        logic [7:0] rate_reg;
        logic [7:0] power_reg;
        logic [7:0] rdata;
        logic sense_en;
        logic lp_active;
        logic conv_strobe;
        logic sample_strobe;
        logic [31:0] conv_cnt;
        logic [1:0] conv_idx;
        logic [BUF_AW-1:0] wr_ptr;
        logic have_sample;
    } apmc_state_s;

    apmc_state_s st_reg;
    apmc_state_s st_next;
    logic mem_we;
    logic [BUF_AW-1:0] mem_raddr;
    logic [SAMPLE_W-1:0] mem_rdata;
    logic [SAMPLE_W-1:0] last_sample;

    // Output period for a rate code: each code step up doubles the rate
    function automatic logic [31:0] apmc_period(input logic [3:0] code);
        logic [3:0] sh;
        sh = APMC_CODE_MAX - code;
        return 32'(SAMPLE_CYC_FAST) << sh;
    endfunction

    // Reduced power uses one conversion per sample instead of four
    function automatic logic apmc_lp_on(input logic [7:0] rate);
        return rate[APMC_LP_BIT] && apmc_lp_eligible(rate[3:0]);
    endfunction

    function automatic logic [31:0] apmc_conv_period(input logic [7:0] rate);
        logic [31:0] p;
        p = apmc_period(rate[3:0]);
        return apmc_lp_on(rate) ? p : (p >> APMC_CONV_SHIFT_NORMAL);
    endfunction

    // The buffer presents the newest word, one cycle after it lands
    assign mem_raddr = st_reg.wr_ptr - BUF_AW'(1);
    // Reads before the first sample show zero, not stale memory
    assign last_sample = st_reg.have_sample ? mem_rdata : '0;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic wr_rate;
        logic wr_power;
        logic restart;
        logic [1:0] conv_last;
        wr_rate = reg_wr && (reg_addr == APMC_RATE_SELECT_OFS);
        wr_power = reg_wr && (reg_addr == APMC_POWER_CONTROL_OFS);
        restart = 1'b0;
        // Reduced power makes every conversion a sample
        conv_last = apmc_lp_on(st_reg.rate_reg) ? 2'h0
                                                : APMC_CONV_LAST_NORMAL;
        st_next = st_reg;
        st_next.rdata = 8'h00;
        st_next.conv_strobe = 1'b0;
        st_next.sample_strobe = 1'b0;
        mem_we = 1'b0;

        if (wr_rate) begin
            st_next.rate_reg = reg_wdata & APMC_RATE_MASK;
            restart = 1'b1;
        end
        if (wr_power) begin
            st_next.power_reg = reg_wdata & APMC_POWER_MASK;
            if (reg_wdata[APMC_MEASURE_BIT]) begin
                if (st_reg.mode == APMC_STANDBY) begin
                    restart = 1'b1;
                end
                st_next.mode = APMC_MEASURE;
            end else begin
                st_next.mode = APMC_STANDBY;
            end
        end

        if (reg_rd) begin
            case (reg_addr)
                APMC_RATE_SELECT_OFS: st_next.rdata = st_reg.rate_reg;
                APMC_POWER_CONTROL_OFS: st_next.rdata = st_reg.power_reg;
                APMC_STATUS_OFS: st_next.rdata = {3'h0, st_reg.have_sample,
                    1'b0, st_reg.lp_active, 1'b0, st_reg.mode};
                APMC_DATA_LO_OFS: st_next.rdata = last_sample[7:0];
                APMC_DATA_HI_OFS: st_next.rdata = last_sample[15:8];
                default: st_next.rdata = 8'h00;
            endcase
        end

        case (st_reg.mode)
            APMC_MEASURE: begin
                // leaving cycle makes no strobe or buffer write
                if (st_next.mode != APMC_MEASURE) begin
                    st_next.conv_cnt = 32'h0;
                    st_next.conv_idx = 2'h0;
                end else if (st_reg.conv_cnt == 32'h0) begin
                    st_next.conv_cnt = apmc_conv_period(st_reg.rate_reg)
                                     - 32'h1;
                    st_next.conv_strobe = 1'b1;
                    if (st_reg.conv_idx == conv_last) begin
                        st_next.conv_idx = 2'h0;
                        st_next.sample_strobe = 1'b1;
                        mem_we = 1'b1;
                        st_next.wr_ptr = st_reg.wr_ptr + BUF_AW'(1);
                        st_next.have_sample = 1'b1;
                    end else begin
                        st_next.conv_idx = st_reg.conv_idx + 2'h1;
                    end
                end else begin
                    st_next.conv_cnt = st_reg.conv_cnt - 32'h1;
                end
            end
            APMC_STANDBY: begin
                st_next.conv_cnt = 32'h0;
                st_next.conv_idx = 2'h0;
            end
            default: st_next.mode = APMC_STANDBY;
        endcase

        // A restart gives the new period in full, never a cut one
        if (restart) begin
            st_next.conv_cnt = apmc_conv_period(st_next.rate_reg) - 32'h1;
            st_next.conv_idx = 2'h0;
        end

        st_next.sense_en = (st_next.mode == APMC_MEASURE);
        // reduced power only in its rate band
        st_next.lp_active = st_next.sense_en && apmc_lp_on(st_next.rate_reg);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Everything holds while clk_en is low, strobes included
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{mode: APMC_STANDBY, rate_reg: APMC_RATE_RESET,
                        power_reg: APMC_POWER_RESET, default: '0};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Only the newest word is readable; older entries are kept for later use
    apmc_sample_mem #(.W(SAMPLE_W), .AW(BUF_AW)) u_mem (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .we(mem_we),
        .waddr(st_reg.wr_ptr),
        .wdata(sample_data),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    assign measure_mode = st_reg.mode;
    assign sense_en = st_reg.sense_en;
    assign lp_active = st_reg.lp_active;
    assign conv_strobe = st_reg.conv_strobe;
    assign sample_strobe = st_reg.sample_strobe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic wr_pwr_q;
    logic wr_rate_q;
    logic [2:0] h_conv;
    logic h_clean;
    assign wr_pwr_q = clk_en && reg_wr && (reg_addr == APMC_POWER_CONTROL_OFS);
    assign wr_rate_q = clk_en && reg_wr && (reg_addr == APMC_RATE_SELECT_OFS);

    // Conversions seen since the last sample, only across undisturbed spans
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            h_conv <= 3'h0;
            h_clean <= 1'b0;
        end else if (clk_en) begin
            if (sample_strobe) begin
                h_conv <= 3'h0;
            end else if (conv_strobe) begin
                h_conv <= h_conv + 3'h1;
            end
            if (wr_pwr_q || wr_rate_q || !sense_en) begin
                h_clean <= 1'b0;
            end else if (sample_strobe) begin
                h_clean <= 1'b1;
            end
        end
    end

    // stays in standby without a measure command
    a_standby_hold: assert property (
        !measure_mode && !(wr_pwr_q && reg_wdata[APMC_MEASURE_BIT])
        |=> !measure_mode)
        else $error("left standby without a measure command");

    a_measure_entry: assert property (
        wr_pwr_q && reg_wdata[APMC_MEASURE_BIT] |=> measure_mode && sense_en)
        else $error("measure bit write did not start measurement");

    a_measure_exit: assert property (
        wr_pwr_q && !reg_wdata[APMC_MEASURE_BIT] |=> !measure_mode ##0 !sense_en)
        else $error("clearing measure bit did not return to standby");

    a_rate_readback: assert property (
        wr_rate_q ##1 (clk_en && reg_rd && reg_addr == APMC_RATE_SELECT_OFS)
        |=> reg_rdata == ($past(reg_wdata, 2) & APMC_RATE_MASK))
        else $error("rate_select readback mismatch");

    a_standby_quiet: assert property (
        !measure_mode |-> !sense_en && !conv_strobe && !sample_strobe)
        else $error("sensing activity while in standby");

    // conversions per sample follow the power mode
    a_conv_per_sample: assert property (
        clk_en && sample_strobe && h_clean
        |-> (h_conv + 3'h1) == (lp_active ? 3'h1 : 3'h4))
        else $error("wrong conversion count per sample");

    // reduced power confined to its band
    a_lp_band: assert property (
        lp_active |-> sense_en && st_reg.rate_reg[APMC_LP_BIT]
            && apmc_lp_eligible(st_reg.rate_reg[3:0]))
        else $error("reduced power active outside its rate band");

    a_buffer_kept: assert property (
        !measure_mode |-> !mem_we ##1 $stable(st_reg.wr_ptr))
        else $error("sample buffer changed in standby");

    // power write leaves rate fields alone
    a_rate_indep: assert property (
        wr_pwr_q && !wr_rate_q |=> $stable(st_reg.rate_reg))
        else $error("power_control write disturbed rate_select");

    a_power_indep: assert property (
        wr_rate_q && !wr_pwr_q |=> $stable(st_reg.power_reg))
        else $error("rate_select write disturbed power_control");

    // read data stand one cycle only
    a_rdata_idle: assert property (
        clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stood beyond its cycle");

    // every sample falls on a conversion
    a_sample_on_conv: assert property (
        sample_strobe |-> conv_strobe)
        else $error("sample strobe without a conversion strobe");

    c_enter_measure: cover property (wr_pwr_q ##1 measure_mode);
    c_lp_sample: cover property (lp_active && sample_strobe);
    c_exit_after_sample: cover property (sample_strobe ##[1:50] !measure_mode);
    c_normal_sample: cover property (sense_en && !lp_active && sample_strobe);
    c_rate_while_measuring: cover property (wr_rate_q && sense_en);
endmodule

// >>> inc/apmc_pkg.sv
package apmc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] APMC_RATE_SELECT_OFS = 8'h2C;
    localparam logic [7:0] APMC_POWER_CONTROL_OFS = 8'h2D;
    localparam logic [7:0] APMC_STATUS_OFS = 8'h40;
    localparam logic [7:0] APMC_DATA_LO_OFS = 8'h41;
    localparam logic [7:0] APMC_DATA_HI_OFS = 8'h42;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int APMC_LP_BIT = 4;
    localparam int APMC_MEASURE_BIT = 3;
    localparam int APMC_CODE_W = 4;
    localparam logic [7:0] APMC_RATE_MASK = 8'h1F;
    localparam logic [7:0] APMC_POWER_MASK = 8'h08;
    localparam logic [7:0] APMC_RATE_RESET = 8'h0A;
    localparam logic [7:0] APMC_POWER_RESET = 8'h00;
    localparam logic [3:0] APMC_CODE_MAX = 4'hF;
    localparam logic [3:0] APMC_LP_CODE_MIN = 4'h7;
    localparam logic [3:0] APMC_LP_CODE_MAX = 4'hC;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int APMC_CLK_HZ = 125_000_000;
    localparam int APMC_ODR_MAX_HZ = 3200;
    // Output period at the fastest rate, rounded down to whole cycles
    localparam int APMC_SAMPLE_CYC_FAST = APMC_CLK_HZ / APMC_ODR_MAX_HZ;
    // Last conversion index of an output sample in normal power (four conversions)
    localparam logic [1:0] APMC_CONV_LAST_NORMAL = 2'h3;
    localparam int APMC_CONV_SHIFT_NORMAL = 2;

    typedef enum logic {
        APMC_STANDBY = 1'b0,
        APMC_MEASURE = 1'b1
    } apmc_mode_e;

    // Codes where reduced power really saves anything
    function automatic logic apmc_lp_eligible(input logic [3:0] code);
        return (code >= APMC_LP_CODE_MIN) && (code <= APMC_LP_CODE_MAX);
    endfunction

endpackage

// >>> verilog/apmc_sample_mem.sv
`timescale 1ns/10ps
module apmc_sample_mem import apmc_pkg::*; #(
    parameter int W = 16,
    parameter int AW = 5
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk) begin
        if (clk_en && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (clk_en) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// >>> bench/apmc_front_model.sv
`timescale 1ns/10ps
module apmc_front_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sense_en,
    input wire logic conv_strobe,
    output logic [15:0] sample_data
);
    // Idle front end toggles, so a stale word can never pass as a sample
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sample_data <= 16'hA5C3;
        end else if (!sense_en) begin
            sample_data <= ~sample_data;
        end else if (conv_strobe) begin
            sample_data <= sample_data + 16'h0101;
        end
    end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench import apmc_pkg::*; ();
    typedef struct {logic [7:0] a, d, r; logic mm, lp;} apmc_tb_reg_s;
    typedef struct {logic [7:0] d; int cyc, nc, ns;} apmc_tb_rate_s;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] sample_data;
    logic measure_mode, sense_en, lp_active, conv_strobe, sample_strobe;
    logic [7:0] rd_val, lo_b;
    logic [15:0] exp_smp, got_smp;
    int miscompares = 0;
    int n_tests = 0;
    int nc, ns;
    apmc_tb_reg_s regs [10] = '{
        '{8'h2C, 8'hFF, 8'h1F, 1'b0, 1'b0}, '{8'h2C, 8'h0A, 8'h0A, 1'b0, 1'b0},
        '{8'h2D, 8'h08, 8'h08, 1'b1, 1'b0}, '{8'h2C, 8'h17, 8'h17, 1'b1, 1'b1},
        '{8'h2C, 8'h1C, 8'h1C, 1'b1, 1'b1}, '{8'h2C, 8'h1D, 8'h1D, 1'b1, 1'b0},
        '{8'h2C, 8'h16, 8'h16, 1'b1, 1'b0}, '{8'h2C, 8'h0C, 8'h0C, 1'b1, 1'b0},
        '{8'h2D, 8'hF7, 8'h00, 1'b0, 1'b0}, '{8'h10, 8'h55, 8'h00, 1'b0, 1'b0}};
    apmc_tb_rate_s rates [5] = '{'{8'h0F, 80, 40, 10}, '{8'h0E, 80, 20, 5},
        '{8'h1C, 256, 4, 4}, '{8'h0C, 256, 16, 4}, '{8'h1D, 256, 32, 8}};

    always #4 core_clk = ~core_clk;

    apmc_power_mode_control #(.SAMPLE_CYC_FAST(8)) dut (
        .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_data(sample_data),
        .measure_mode(measure_mode), .sense_en(sense_en),
        .lp_active(lp_active), .conv_strobe(conv_strobe),
        .sample_strobe(sample_strobe));

    apmc_front_model front (
        .core_clk(core_clk), .rstn(rstn), .sense_en(sense_en),
        .conv_strobe(conv_strobe), .sample_data(sample_data));

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask

    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_smp(input int lim);
        for (int i = 0; i <= lim; i++) begin
            if (sample_strobe === 1'b1) return;
            @(posedge core_clk);
            #1;
        end
        miscompares++;
        $display("BAD sample_strobe exp 1 got 0");
        close_out();
    endtask

    task automatic wait_conv(input int lim);
        for (int i = 0; i <= lim; i++) begin
            if (conv_strobe === 1'b1) return;
            @(posedge core_clk);
            #1;
        end
        miscompares++;
        $display("BAD conv_strobe exp 1 got 0");
        close_out();
    endtask

    task automatic count(input int cyc);
        nc = 0;
        ns = 0;
        for (int i = 0; i < cyc; i++) begin
            if (conv_strobe === 1'b1) nc++;
            if (sample_strobe === 1'b1) ns++;
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic rd_smp(output logic [15:0] v);
        rd(APMC_DATA_LO_OFS, lo_b);
        rd(APMC_DATA_HI_OFS, rd_val);
        v = {rd_val, lo_b};
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk("measure_mode", 16'(1'b0), 16'(measure_mode));
        chk("sense_en", 16'(1'b0), 16'(sense_en));
        rd(APMC_RATE_SELECT_OFS, rd_val);
        chk("rate_select", 16'(APMC_RATE_RESET), 16'(rd_val));
        rd(APMC_POWER_CONTROL_OFS, rd_val);
        chk("power_control", 16'(APMC_POWER_RESET), 16'(rd_val));
        $display("test reset done");
        foreach (regs[i]) begin
            wr(regs[i].a, regs[i].d);
            chk("measure_mode", 16'(regs[i].mm), 16'(measure_mode));
            chk("sense_en", 16'(regs[i].mm), 16'(sense_en));
            chk("lp_active", 16'(regs[i].lp), 16'(lp_active));
            rd(regs[i].a, rd_val);
            chk("reg read", 16'(regs[i].r), 16'(rd_val));
        end
        $display("test register rows done");
        wr(APMC_POWER_CONTROL_OFS, 8'h08);
        foreach (rates[i]) begin
            wr(APMC_RATE_SELECT_OFS, rates[i].d);
            // Skip a strobe left over from the old timing
            @(posedge core_clk);
            #1;
            wait_conv(3000);
            count(rates[i].cyc);
            chk("conv count", 16'(rates[i].nc), 16'(nc));
            chk("sample count", 16'(rates[i].ns), 16'(ns));
        end
        $display("test rate rows done");
        wr(APMC_POWER_CONTROL_OFS, 8'h00);
        wr(APMC_RATE_SELECT_OFS, 8'h0F);
        wr(APMC_POWER_CONTROL_OFS, 8'h08);
        wait_smp(100);
        exp_smp = sample_data;
        wr(APMC_POWER_CONTROL_OFS, 8'h00);
        rd_smp(got_smp);
        chk("stored sample", exp_smp, got_smp);
        rd(APMC_STATUS_OFS, rd_val);
        chk("status", 16'h0010, 16'(rd_val));
        count(40);
        chk("standby convs", 16'h0000, 16'(nc));
        chk("standby samples", 16'h0000, 16'(ns));
        rd_smp(got_smp);
        chk("kept sample", exp_smp, got_smp);
        $display("test standby keeps buffer done");
        // Write then read with no gap between the strobes
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= APMC_RATE_SELECT_OFS;
        reg_wdata <= 8'hE9;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rate back to back", 16'(8'hE9 & APMC_RATE_MASK), 16'(reg_rdata));
        $display("test back to back done");
        wr(APMC_POWER_CONTROL_OFS, 8'h08);
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(APMC_POWER_CONTROL_OFS, 8'h00);
        @(posedge core_clk);
        clk_en <= 1'b1;
        #1;
        chk("frozen measure_mode", 16'(1'b1), 16'(measure_mode));
        @(posedge core_clk);
        rstn <= 1'b0;
        #1;
        chk("reset measure_mode", 16'(1'b0), 16'(measure_mode));
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rd(APMC_RATE_SELECT_OFS, rd_val);
        chk("rate after reset", 16'(APMC_RATE_RESET), 16'(rd_val));
        $display("test clock enable and reset done");
        close_out();
    end
endmodule
